// ### hw/auo_map.svh
/*
 * Holds the byte addresses, reset values and command codes of the arithmetic
 * unit operand registers.
 * Assumes it is included by its bare name, after any timescale directive.
 */
`ifndef AUO_MAP_SVH
`define AUO_MAP_SVH

// ****************************************
// register byte addresses
// ****************************************
`define AUO_ADDR_A_LOW       8'hA2
`define AUO_ADDR_A_HIGH      8'hA3
`define AUO_ADDR_C_BYTE0     8'hA4
`define AUO_ADDR_C_BYTE1     8'hA5
`define AUO_ADDR_C_BYTE2     8'hA6
`define AUO_ADDR_C_BYTE3     8'hA7
`define AUO_ADDR_DIV_ALIAS   8'hB1
`define AUO_ADDR_B_LOW       8'hB2
`define AUO_ADDR_B_HIGH      8'hB3

// ****************************************
// reset values
// ****************************************
`define AUO_RST_BYTE         8'h00
`define AUO_RST_HALF         16'h0000
`define AUO_RST_WORD         32'h0000_0000

// ****************************************
// operand clear command codes
// ****************************************
`define AUO_CLR_NONE         3'h0
`define AUO_CLR_A            3'h1
`define AUO_CLR_B            3'h2
`define AUO_CLR_C            3'h3
`define AUO_CLR_ALL          3'h5

// ****************************************
// adder source select codes
// ****************************************
`define AUO_SRC_ZERO         2'h0
`define AUO_SRC_PREV         2'h2

// ****************************************
// division range limits
// ****************************************
`define AUO_DIV_ZERO         16'h0000
`define AUO_DIV_MIN_A        16'h8000
`define AUO_DIV_NEG_ONE      16'hFFFF

`endif

// ### hw/auo_pkg.sv
/*
 * Holds the types shared by the operand register bank and its divider.
 * Assumes nothing of its surroundings.
 */
package auo_pkg;

    // ****************************************
    // operand register set
    // ****************************************
    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
        logic [31:0] c;
    } auo_operands_t;

    // ****************************************
    // division answer
    // ****************************************
    typedef struct packed {
        logic [15:0] quotient;
        logic [15:0] remainder;
        logic        range_error;
    } auo_div_t;

endpackage

// ### hw/auo_divider.sv
/*
 * Holds the combinational signed 16-bit divider and its range check.
 * Assumes operands come from registers on the same clock.
 */
`timescale 1ns/1ns
`include "auo_map.svh"

module auo_divider #(
    parameter int WIDTH = 16
) (
    // operands
    input  wire logic [WIDTH-1:0] i_dividend,
    input  wire logic [WIDTH-1:0] i_divisor,
    // answer
    output auo_pkg::auo_div_t     o_answer
);

    if (WIDTH != 16) begin : g_width_check
        $error("auo_divider serves only 16-bit operands");
    end

    // ****************************************
    // range check and division
    // ****************************************
    function automatic logic out_of_range(input logic [15:0] a, input logic [15:0] b);
        out_of_range = (b == `AUO_DIV_ZERO) ||
                       ((a == `AUO_DIV_MIN_A) && (b == `AUO_DIV_NEG_ONE));
    endfunction

    always_comb begin
        o_answer = '0;
        o_answer.range_error = out_of_range(i_dividend, i_divisor);
        if (!o_answer.range_error) begin
            o_answer.quotient  = 16'($signed(i_dividend) / $signed(i_divisor));
            o_answer.remainder = 16'($signed(i_dividend) % $signed(i_divisor));
        end
    end

endmodule

// ### hw/auo_operand_regs.sv
/*
 * Holds the operand input register bank of the arithmetic unit: operands
 * A and B, the 32-bit addend C, the division alias byte and adder source mux.
 * Assumes a byte-wide special function register bus on the system clock and
 * a previous result word, clear command and source select from the unit.
 */
// Overview of operation
// - A and B are 16-bit multiply operands
// - add word is A high, B low
// - writing divisor alias sets division mode
// - 32-bit C register feeds addition only
// - adder input takes C, zero or previous result
// - A bytes at A2H, A3H, reset zero
// - B bytes at B2H, B3H, alias B1H
// - C bytes 0 and 1 at A4H, A5H
// - C bytes 2 and 3 at A6H, A7H
// - select: 00 zero, x1 C, 10 previous
// - division result: quotient high, remainder low
// - range error on zero or overflow divide
`timescale 1ns/1ns
`include "auo_map.svh"

module auo_operand_regs (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // register bus
    input  wire logic [7:0]  i_sfr_addr,
    input  wire logic [7:0]  i_sfr_wdata,
    input  wire logic        i_sfr_wr,
    input  wire logic        i_sfr_rd,
    output logic      [7:0]  o_sfr_rdata,
    output logic             o_sfr_hit,
    // unit control
    input  wire logic [2:0]  i_clear_cmd,
    input  wire logic [1:0]  i_adder_source_select,
    input  wire logic [31:0] i_previous_result,
    // operand outputs
    output logic      [15:0] o_operand_a,
    output logic      [15:0] o_operand_b,
    output logic      [31:0] o_addend_c,
    output logic      [31:0] o_add_word_a,
    output logic      [31:0] o_add_word_b,
    // division outputs
    output logic             o_div_mode,
    output logic      [31:0] o_div_result,
    output logic             o_divide_range_error
);

    // ****************************************
    // state
    // ****************************************
    auo_pkg::auo_operands_t ops;
    auo_pkg::auo_operands_t next_ops;
    auo_pkg::auo_div_t      div_ans;
    logic                   div_mode;
    logic                   next_div_mode;
    logic [31:0]            add_a;
    logic [31:0]            next_add_a;
    logic [31:0]            add_b;
    logic [31:0]            next_add_b;
    logic [31:0]            div_res;
    logic [31:0]            next_div_res;
    logic                   div_err;
    logic                   next_div_err;
    logic [7:0]             rdata;
    logic [7:0]             next_rdata;

    function automatic logic is_mapped(input logic [7:0] addr);
        case (addr)
            `AUO_ADDR_A_LOW, `AUO_ADDR_A_HIGH, `AUO_ADDR_C_BYTE0, `AUO_ADDR_C_BYTE1,
            `AUO_ADDR_C_BYTE2, `AUO_ADDR_C_BYTE3, `AUO_ADDR_DIV_ALIAS,
            `AUO_ADDR_B_LOW, `AUO_ADDR_B_HIGH: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    auo_divider #(
        .WIDTH (16)
    ) u_divider (
        .i_dividend (ops.a),
        .i_divisor  (ops.b),
        .o_answer   (div_ans)
    );

    // ****************************************
    // register writes and clears
    // ****************************************
    always_comb begin
        next_ops      = ops;
        next_div_mode = div_mode;
        case (i_clear_cmd)
            `AUO_CLR_A: next_ops.a = `AUO_RST_HALF;
            `AUO_CLR_B: next_ops.b = `AUO_RST_HALF;
            `AUO_CLR_C: next_ops.c = `AUO_RST_WORD;
            `AUO_CLR_ALL: begin
                next_ops      = '0;
                next_div_mode = 1'b0;
            end
            default: ;
        endcase
        if (i_sfr_wr) begin
            case (i_sfr_addr)
                `AUO_ADDR_A_LOW:   next_ops.a[7:0]   = i_sfr_wdata;
                `AUO_ADDR_A_HIGH:  next_ops.a[15:8]  = i_sfr_wdata;
                `AUO_ADDR_C_BYTE0: next_ops.c[7:0]   = i_sfr_wdata;
                `AUO_ADDR_C_BYTE1: next_ops.c[15:8]  = i_sfr_wdata;
                `AUO_ADDR_C_BYTE2: next_ops.c[23:16] = i_sfr_wdata;
                `AUO_ADDR_C_BYTE3: next_ops.c[31:24] = i_sfr_wdata;
                `AUO_ADDR_DIV_ALIAS: begin
                    next_ops.b[7:0] = i_sfr_wdata;
                    next_div_mode   = 1'b1;
                end
                `AUO_ADDR_B_LOW: begin
                    next_ops.b[7:0] = i_sfr_wdata;
                    next_div_mode   = 1'b0;
                end
                `AUO_ADDR_B_HIGH:  next_ops.b[15:8]  = i_sfr_wdata;
                default: ;
            endcase
        end
    end

    // ****************************************
    // adder inputs, division answer, read data
    // ****************************************
    always_comb begin
        next_add_a = {ops.a, ops.b};
        case (i_adder_source_select)
            `AUO_SRC_ZERO: next_add_b = `AUO_RST_WORD;
            `AUO_SRC_PREV: next_add_b = i_previous_result;
            default:       next_add_b = ops.c;
        endcase
        next_div_res = {div_ans.quotient, div_ans.remainder};
        next_div_err = div_ans.range_error;
        next_rdata   = `AUO_RST_BYTE;
        if (i_sfr_rd) begin
            case (i_sfr_addr)
                `AUO_ADDR_A_LOW:    next_rdata = ops.a[7:0];
                `AUO_ADDR_A_HIGH:   next_rdata = ops.a[15:8];
                `AUO_ADDR_C_BYTE0:  next_rdata = ops.c[7:0];
                `AUO_ADDR_C_BYTE1:  next_rdata = ops.c[15:8];
                `AUO_ADDR_C_BYTE2:  next_rdata = ops.c[23:16];
                `AUO_ADDR_C_BYTE3:  next_rdata = ops.c[31:24];
                `AUO_ADDR_DIV_ALIAS,
                `AUO_ADDR_B_LOW:    next_rdata = ops.b[7:0];
                `AUO_ADDR_B_HIGH:   next_rdata = ops.b[15:8];
                default:            next_rdata = `AUO_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ops      <= '0;
            div_mode <= 1'b0;
            add_a    <= `AUO_RST_WORD;
            add_b    <= `AUO_RST_WORD;
            div_res  <= `AUO_RST_WORD;
            div_err  <= 1'b0;
            rdata    <= `AUO_RST_BYTE;
        end else begin
            ops      <= next_ops;
            div_mode <= next_div_mode;
            add_a    <= next_add_a;
            add_b    <= next_add_b;
            div_res  <= next_div_res;
            div_err  <= next_div_err;
            rdata    <= next_rdata;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_operand_a          = ops.a;
    assign o_operand_b          = ops.b;
    assign o_addend_c           = ops.c;
    assign o_add_word_a         = add_a;
    assign o_add_word_b         = add_b;
    assign o_div_mode           = div_mode;
    assign o_div_result         = div_res;
    assign o_divide_range_error = div_err;
    assign o_sfr_rdata          = rdata;
    assign o_sfr_hit            = (i_sfr_wr || i_sfr_rd) && is_mapped(i_sfr_addr);

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    sequence alias_write_s;
        i_sfr_wr && i_sfr_addr == `AUO_ADDR_DIV_ALIAS && i_clear_cmd == `AUO_CLR_NONE;
    endsequence

    sequence alias_read_s;
        i_sfr_rd && !i_sfr_wr && i_sfr_addr == `AUO_ADDR_B_LOW && i_clear_cmd == `AUO_CLR_NONE;
    endsequence

    alias_sets_div_a: assert property (alias_write_s |=> o_div_mode)
        else $error("alias write did not set division mode");
    alias_readback_a: assert property ((alias_write_s ##1 alias_read_s) |=>
            o_sfr_rdata == $past(i_sfr_wdata, 2))
        else $error("alias byte not read back at low byte");
    a_low_write_a: assert property (i_sfr_wr && i_sfr_addr == `AUO_ADDR_A_LOW &&
            i_clear_cmd == `AUO_CLR_NONE |=> o_operand_a[7:0] == $past(i_sfr_wdata))
        else $error("operand a low byte not written");
    c_top_write_a: assert property (i_sfr_wr && i_sfr_addr == `AUO_ADDR_C_BYTE3 &&
            i_clear_cmd == `AUO_CLR_NONE |=> o_addend_c[31:24] == $past(i_sfr_wdata))
        else $error("addend top byte not written");
    concat_word_a: assert property (##1 o_add_word_a == {$past(o_operand_a), $past(o_operand_b)})
        else $error("add word a is not a over b");
    src_zero_a: assert property (i_adder_source_select == `AUO_SRC_ZERO |=> o_add_word_b == 0)
        else $error("zero source not zero");
    src_c_a: assert property (i_adder_source_select[0] |=> o_add_word_b == $past(o_addend_c))
        else $error("c source not routed");
    src_prev_a: assert property (i_adder_source_select == `AUO_SRC_PREV |=>
            o_add_word_b == $past(i_previous_result))
        else $error("previous source not routed");
    div_zero_err_a: assert property (o_operand_b == `AUO_DIV_ZERO |=> o_divide_range_error)
        else $error("divide by zero not flagged");
    div_layout_a: assert property (o_operand_b == 16'h0003 && o_operand_a == 16'h0007 |=>
            o_div_result == 32'h0002_0001 && !o_divide_range_error)
        else $error("quotient and remainder misplaced");
    operand_hold_a: assert property (!i_sfr_wr && i_clear_cmd == `AUO_CLR_NONE |=>
            $stable(o_operand_a) && $stable(o_operand_b) && $stable(o_addend_c))
        else $error("operand changed without write");
    clear_a_a: assert property (i_clear_cmd == `AUO_CLR_A && !i_sfr_wr |=> o_operand_a == 0)
        else $error("clear of a failed");

endmodule

// ### verif/auo_core_model.sv
/*
 * Core-side master of the byte register bus.
 * Assumes the bench calls put and idle in order, one bus cycle each.
 */
`timescale 1ns/1ns

module auo_core_model (
    // clock
    input  wire logic       i_clk,
    // register bus
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_wr,
    output logic            o_rd
);
    // ****************************************
    // bus cycles
    // ****************************************
    initial begin
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // request held until the next edge takes it
    task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_wdata = d;
        o_wr = w;
        o_rd = ~w;
    endtask

    // released lines show the inverse of the last value
    task automatic idle();
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~o_addr;
        o_wdata = ~o_wdata;
    endtask
endmodule

// ### verif/arith_unit_operand_inputs_tb_top.sv
/*
 * Self-checking bench of the operand register bank.
 * Assumes the core model drives the bus and a watcher compares notes.
 */
`timescale 1ns/1ns
`include "auo_map.svh"

module arith_unit_operand_inputs_tb_top;
    typedef struct packed {
        logic [2:0]  sel;
        logic [63:0] val;
    } auo_note_t;
    // ****************************************
    // signals and design
    // ****************************************
    logic                   i_clk = 1'b0;
    logic                   i_rst_b = 1'b0;
    logic [7:0]             addr, wdata, rdata;
    logic                   wr, rd, hit, div_mode, div_err, bad;
    logic [2:0]             clear_cmd = 3'h0;
    logic [1:0]             src_sel = 2'h0;
    logic [31:0]            prev = 32'h0;
    logic [31:0]            add_a, add_b, div_res, cw;
    logic [31:0]            lfsr = 32'hB79C373F;
    logic [15:0]            da, db, q, r;
    logic [63:0]            exp;
    logic [7:0]             v [8];
    auo_pkg::auo_operands_t ops;
    auo_note_t              notes [$];
    auo_note_t              cur;
    logic                   look = 1'b0;
    logic                   rd_d = 1'b0;
    logic                   hit_d = 1'b0;
    int                     n_fail = 0;
    int                     samples_checked = 0;
    logic [7:0]             addr_tab [10] = '{`AUO_ADDR_A_LOW, `AUO_ADDR_A_HIGH,
        `AUO_ADDR_C_BYTE0, `AUO_ADDR_C_BYTE1, `AUO_ADDR_C_BYTE2, `AUO_ADDR_C_BYTE3,
        `AUO_ADDR_B_LOW, `AUO_ADDR_B_HIGH, `AUO_ADDR_DIV_ALIAS, 8'hA8};
    logic [31:0]            dv [6] = '{32'h0007_0003, 32'h0064_0007, 32'hFF9C_0007, 32'h8000_FFFF,
        32'h1234_0000, 32'h7FFF_FFFF};

    always #10 i_clk = ~i_clk;

    auo_operand_regs u_auo_operand_regs (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_sfr_addr(addr), .i_sfr_wdata(wdata), .i_sfr_wr(wr), .i_sfr_rd(rd),
        .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_clear_cmd(clear_cmd),
        .i_adder_source_select(src_sel), .i_previous_result(prev),
        .o_operand_a(ops.a), .o_operand_b(ops.b), .o_addend_c(ops.c),
        .o_add_word_a(add_a), .o_add_word_b(add_b), .o_div_mode(div_mode),
        .o_div_result(div_res), .o_divide_range_error(div_err));
    auo_core_model u_auo_core_model (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction

    function automatic logic [63:0] seen(input logic [2:0] s);
        case (s)
            3'h0: return {55'h0, hit_d, rdata};
            3'h1: return {63'h0, div_mode};
            3'h4: return {32'h0, add_a};
            3'h5: return {32'h0, add_b};
            3'h6: return {30'h0, div_mode, div_err, div_res};
            default: return ops;
        endcase
    endfunction

    task automatic wrb(input logic [7:0] a, input logic [7:0] d);
        u_auo_core_model.put(a, d, 1'b1);
    endtask

    task automatic rdb(input logic [7:0] a, input logic [7:0] e);
        // only 8'hA8 is used as an unmapped address
        notes.push_back({3'h0, 55'h0, (a != 8'hA8), e});
        u_auo_core_model.put(a, 8'h00, 1'b0);
    endtask

    task automatic chk(input logic [2:0] s, input logic [63:0] e);
        u_auo_core_model.idle();
        notes.push_back({s, e});
        @(posedge i_clk);
        #1;
        look = 1'b1;
        @(posedge i_clk);
        #1;
        look = 1'b0;
    endtask

    task automatic report_and_stop();
        if (n_fail == 0 && samples_checked > 0 && notes.size() == 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // watcher
    // ****************************************
    always @(posedge i_clk) begin
        rd_d <= rd;
        hit_d <= hit;
        if ((rd_d || look) && notes.size() > 0) begin
            cur = notes.pop_front();
            samples_checked++;
            if (seen(cur.sel) !== cur.val) begin
                n_fail++;
                $display("BAD %0t sel %0d got %h want %h", $time, cur.sel, seen(cur.sel), cur.val);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        n_fail++;
        report_and_stop();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (16) @(posedge i_clk);
        #1;
        i_rst_b = 1'b1;
        for (int i = 0; i < 10; i++) rdb(addr_tab[i], 8'h00);
        chk(3'h6, {30'h0, 1'b0, 1'b1, 32'h0});
        for (int i = 0; i < 8; i++) begin
            v[i] = rnd();
            wrb(addr_tab[i], v[i]);
        end
        wrb(8'hA8, rnd());
        for (int i = 0; i < 8; i++) rdb(addr_tab[i], v[i]);
        rdb(`AUO_ADDR_DIV_ALIAS, v[6]);
        rdb(8'hA8, 8'h00);
        cw = {v[5], v[4], v[3], v[2]};
        chk(3'h7, {v[1], v[0], v[7], v[6], cw});
        chk(3'h4, {32'h0, v[1], v[0], v[7], v[6]});
        prev = {rnd(), rnd(), rnd(), rnd()};
        for (int s = 0; s < 4; s++) begin
            src_sel = 2'(s);
            chk(3'h5, {32'h0, s == 0 ? 32'h0 : (s == 2 ? prev : cw)});
        end
        for (int k = 0; k < 6; k++) begin
            {da, db} = dv[k];
            wrb(`AUO_ADDR_A_LOW, da[7:0]);
            wrb(`AUO_ADDR_A_HIGH, da[15:8]);
            wrb(`AUO_ADDR_B_HIGH, db[15:8]);
            wrb(`AUO_ADDR_DIV_ALIAS, db[7:0]);
            rdb(`AUO_ADDR_B_LOW, db[7:0]);
            bad = db == 16'h0000 || (da == 16'h8000 && db == 16'hFFFF);
            {q, r} = 32'h0;
            if (!bad) begin
                q = 16'($signed(da) / $signed(db));
                r = 16'($signed(da) % $signed(db));
            end
            chk(3'h6, {30'h0, 1'b1, bad, q, r});
        end
        wrb(`AUO_ADDR_B_LOW, 8'h01);
        chk(3'h1, 64'h0);
        exp = {16'h7FFF, 16'hFF01, cw};
        for (int c = 1; c < 4; c++) begin
            clear_cmd = 3'(c);
            if (c == 1) exp[63:48] = 16'h0000;
            if (c == 2) exp[47:32] = 16'h0000;
            if (c == 3) exp[31:0] = 32'h0000_0000;
            chk(3'h7, exp);
            clear_cmd = `AUO_CLR_NONE;
        end
        wrb(`AUO_ADDR_A_HIGH, 8'h5A);
        wrb(`AUO_ADDR_DIV_ALIAS, 8'h03);
        wrb(`AUO_ADDR_C_BYTE3, 8'hC3);
        chk(3'h1, 64'h1);
        clear_cmd = `AUO_CLR_ALL;
        chk(3'h7, 64'h0);
        chk(3'h1, 64'h0);
        clear_cmd = `AUO_CLR_NONE;
        u_auo_core_model.idle();
        report_and_stop();
    end
endmodule
